// ---- shared/pin_routing_pkg.sv ----
// constants for the serial port pin routing block: register map,
// field layout, reset values and select codes.
// assumes an 8-bit register file reached over a 32-bit AHB-Lite slave.
package pin_routing_pkg;

  // ***************************************************************
  // register indices; byte address is four times the index
  // ***************************************************************
  localparam logic [7:0] IDX_SRC   = 8'h0F; // primary_port_source_config
  localparam logic [7:0] IDX_FUNC  = 8'h10; // output_pin_function_config
  localparam logic [7:0] IDX_SCLK  = 8'h11; // secondary_port_clock_config
  localparam logic [7:0] IDX_SIN   = 8'h12; // secondary_input_select_config
  localparam int         ADDR_LSB  = 2;
  localparam int         IDX_W     = 8;

  // ***************************************************************
  // reset values and writable-bit masks
  // ***************************************************************
  localparam logic [7:0] RST_SRC   = 8'h00;
  localparam logic [7:0] RST_FUNC  = 8'h52;
  localparam logic [7:0] RST_SCLK  = 8'h80;
  localparam logic [7:0] RST_SIN   = 8'h00;
  localparam logic [7:0] WM_SRC    = 8'h7F;
  localparam logic [7:0] WM_FUNC   = 8'hFF;
  localparam logic [7:0] WM_SCLK   = 8'hFE;
  localparam logic [7:0] WM_SIN    = 8'hFC;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int AUX_LSB   = 5; // aux clock select, 2 bits
  localparam int DIN2_LSB  = 2; // primary_second_input_source, 3 bits
  localparam int PBCLK_BIT = 1; // primary_bitclk_source
  localparam int PFS_BIT   = 0; // primary_framesync_source
  localparam int FN_LSB    = 4; // out pin function, 4 bits
  localparam int LVL_BIT   = 3; // out_pin_level
  localparam int DRV_LSB   = 0; // out_pin_drive_style, 3 bits
  localparam int PEN_BIT   = 7; // primary_input_enable
  localparam int SFS_LSB   = 4; // secondary_framesync_source, 3 bits
  localparam int SBCLK_LSB = 1; // secondary_bitclk_source, 3 bits

  // ***************************************************************
  // select codes
  // ***************************************************************
  localparam logic [2:0] SEL_OFF   = 3'h0;
  localparam logic [2:0] SEL_BIDIR = 3'h1;
  localparam logic [2:0] SEL_PINB  = 3'h2;
  localparam logic [2:0] SEL_PINA  = 3'h3;
  localparam logic [2:0] SEL_OUTP  = 3'h4;
  localparam logic [2:0] SEL_PRIM  = 3'h5;

  typedef enum logic [3:0] {
    FN_OFF, FN_IN, FN_GPO, FN_IRQ, FN_DENSITY_MOD_CLOCK_OUT, FN_PDOUT, FN_PDOUT2,
    FN_SDOUT, FN_SDOUT2, FN_SBCLK, FN_SFS, FN_GENERAL_CLOCK_OUTPUT, FN_MUXED,
    FN_LOOP, FN_RSV14, FN_RSV15
  } pin_func_t;

  typedef enum logic [2:0] {
    DRV_HIZ, DRV_PUSHPULL, DRV_LOW_WEAKHI, DRV_LOW_HIZ,
    DRV_WEAKLO_HI, DRV_HIZ_HI, DRV_RSV6, DRV_RSV7
  } drive_style_t;

  // synchroniser lanes for the pin inputs
  localparam int SY_BIDIR = 0;
  localparam int SY_PINA  = 1;
  localparam int SY_PINB  = 2;
  localparam int SY_BCLK  = 3;
  localparam int SY_FS    = 4;
  localparam int SY_DIN   = 5;
  localparam int SY_OUTP  = 6;
  localparam int SY_N     = 7;

endpackage

// ---- logic/serial_port_pin_routing.sv ----
// serial port pin routing: pin selects, out pin function and drive.
// assumes one hclk domain; pin inputs are asynchronous and are
// synchronised here; data and clock sources from logic share hclk.
//
// Overview of operation
// - aux clock from off, bidir pin one, input pin b or a by bits 6-5
// - primary second input from bits 4-2; 6-7 reserved
// - primary bit clock from own pin, or secondary bit clock if set
// - primary frame sync from own pin, or secondary frame sync if set
// - reserved bits read zero; software writes zero there
// - out pin function from bits 7-4, reset 5; codes 0-4 basic
// - codes 5-8 route primary and secondary data outputs to pin
// - codes 9-13 route secondary clocks, clock out, muxed, loopback
// - general-purpose output drives the level held in bit 3
// - drive style from bits 2-0, reset 2, six styles
// - primary data input passes only while bit 7 set; resets set
// - secondary frame sync from bits 6-4; 5 reuses primary
// - secondary bit clock from bits 3-1; 5 reuses primary
// - secondary port disabled if either source field is zero
`timescale 1ns/1ns
`default_nettype none

module serial_port_pin_routing (
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  input  wire  logic        bidir_pin_one_in,
  input  wire  logic        input_pin_a,
  input  wire  logic        input_pin_b,
  input  wire  logic        bitclk_pin,
  input  wire  logic        framesync_pin,
  input  wire  logic        data_in_pin,
  input  wire  logic        out_pin_in,
  input  wire  logic        primary_data_out,
  input  wire  logic        primary_data_out2,
  input  wire  logic        secondary_data_out,
  input  wire  logic        secondary_data_out2,
  input  wire  logic        muxed_data_out,
  input  wire  logic        irq_level,
  input  wire  logic        density_mod_clock_out,
  input  wire  logic        general_clock_output,
  output logic        out_pin_out,
  output logic        out_pin_oe,
  output logic        out_pin_pullup,
  output logic        out_pin_pulldown,
  output logic        aux_clock,
  output logic        primary_second_input,
  output logic        primary_bitclk,
  output logic        primary_framesync,
  output logic        primary_data_in,
  output logic        secondary_bitclk,
  output logic        secondary_framesync,
  output logic        secondary_enabled
);

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [pin_routing_pkg::SY_N-1:0] pins_raw;
  logic [pin_routing_pkg::SY_N-1:0] meta_r;
  logic [pin_routing_pkg::SY_N-1:0] syn_r;

  assign pins_raw = {out_pin_in, data_in_pin, framesync_pin,
                     bitclk_pin, input_pin_b, input_pin_a,
                     bidir_pin_one_in};

  // two flops per lane; only the second lane flop is read elsewhere
  genvar g;
  generate
    for (g = 0; g < pin_routing_pkg::SY_N; g++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_r[g] <= 1'b0;
          syn_r[g]  <= 1'b0;
        end else begin
          meta_r[g] <= pins_raw[g];
          syn_r[g]  <= meta_r[g];
        end
      end
    end
  endgenerate

  // ***************************************************************
  // AHB-Lite slave, one wait state per transfer
  // ***************************************************************
  logic [7:0] src_r;
  logic [7:0] func_r;
  logic [7:0] sclk_r;
  logic [7:0] sin_r;
  logic       pend_r;
  logic       pwr_r;
  logic [pin_routing_pkg::IDX_W-1:0] pidx_r;
  logic       hreadyout_r;
  logic [31:0] hrdata_r;
  logic       acc;
  logic [pin_routing_pkg::IDX_W-1:0] aidx;
  logic [7:0] rd_nxt;

  assign acc  = hsel && hready && htrans[1];
  assign aidx = haddr[pin_routing_pkg::ADDR_LSB +: pin_routing_pkg::IDX_W];

  // capture the address phase; data phase is held low one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r      <= 1'b0;
      pwr_r       <= 1'b0;
      pidx_r      <= '0;
      hreadyout_r <= 1'b1;
    end else if (acc) begin
      pend_r      <= 1'b1;
      pwr_r       <= hwrite;
      pidx_r      <= aidx;
      hreadyout_r <= 1'b0;
    end else begin
      pend_r      <= 1'b0;
      hreadyout_r <= 1'b1;
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    case (pidx_r)
      pin_routing_pkg::IDX_SRC:  rd_nxt = src_r;
      pin_routing_pkg::IDX_FUNC: rd_nxt = func_r;
      pin_routing_pkg::IDX_SCLK: rd_nxt = sclk_r;
      pin_routing_pkg::IDX_SIN:  rd_nxt = sin_r;
      default:                   rd_nxt = 8'h00;
    endcase
  end

  // read data registered in the wait cycle, upper bits zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (pend_r && !pwr_r) begin
      hrdata_r <= {24'h00_0000, rd_nxt};
    end
  end

  // register writes; reserved bits masked so they stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_r  <= pin_routing_pkg::RST_SRC;
      func_r <= pin_routing_pkg::RST_FUNC;
      sclk_r <= pin_routing_pkg::RST_SCLK;
      sin_r  <= pin_routing_pkg::RST_SIN;
    end else if (pend_r && pwr_r) begin
      case (pidx_r)
        pin_routing_pkg::IDX_SRC:
          src_r <= hwdata[7:0] & pin_routing_pkg::WM_SRC;
        pin_routing_pkg::IDX_FUNC:
          func_r <= hwdata[7:0] & pin_routing_pkg::WM_FUNC;
        pin_routing_pkg::IDX_SCLK:
          sclk_r <= hwdata[7:0] & pin_routing_pkg::WM_SCLK;
        pin_routing_pkg::IDX_SIN:
          sin_r <= hwdata[7:0] & pin_routing_pkg::WM_SIN;
        default: ;
      endcase
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // ***************************************************************
  // field decode
  // ***************************************************************
  logic [1:0] aux_sel;
  logic [2:0] din2_sel;
  logic [2:0] sfs_sel;
  logic [2:0] sbclk_sel;
  pin_routing_pkg::pin_func_t    fn;
  pin_routing_pkg::drive_style_t drv;
  logic       lvl;
  logic       sec_on;

  assign aux_sel   = src_r[pin_routing_pkg::AUX_LSB +: 2];
  assign din2_sel  = src_r[pin_routing_pkg::DIN2_LSB +: 3];
  assign sfs_sel   = sclk_r[pin_routing_pkg::SFS_LSB +: 3];
  assign sbclk_sel = sclk_r[pin_routing_pkg::SBCLK_LSB +: 3];
  assign fn  = pin_routing_pkg::pin_func_t'(func_r[pin_routing_pkg::FN_LSB +: 4]);
  assign drv = pin_routing_pkg::drive_style_t'(func_r[pin_routing_pkg::DRV_LSB +: 3]);
  assign lvl = func_r[pin_routing_pkg::LVL_BIT];
  assign sec_on = (sfs_sel != pin_routing_pkg::SEL_OFF) &&
                  (sbclk_sel != pin_routing_pkg::SEL_OFF);

  // shared source picker for 3-bit select fields
  function automatic logic pick3(input logic [2:0] sel,
                                 input logic [pin_routing_pkg::SY_N-1:0] s,
                                 input logic code4,
                                 input logic code5);
    case (sel)
      pin_routing_pkg::SEL_BIDIR: pick3 = s[pin_routing_pkg::SY_BIDIR];
      pin_routing_pkg::SEL_PINB:  pick3 = s[pin_routing_pkg::SY_PINB];
      pin_routing_pkg::SEL_PINA:  pick3 = s[pin_routing_pkg::SY_PINA];
      pin_routing_pkg::SEL_OUTP:  pick3 = code4;
      pin_routing_pkg::SEL_PRIM:  pick3 = code5;
      default:                    pick3 = 1'b0;
    endcase
  endfunction

  // ***************************************************************
  // input routing
  // ***************************************************************
  logic sbclk_nxt;
  logic sfs_nxt;
  logic aux_nxt;

  // secondary clocks; code 4 reserved, 5 takes the primary pins
  always_comb begin
    sbclk_nxt = 1'b0;
    sfs_nxt   = 1'b0;
    if (sec_on) begin
      sbclk_nxt = pick3(sbclk_sel, syn_r, 1'b0,
                        syn_r[pin_routing_pkg::SY_BCLK]);
      sfs_nxt   = pick3(sfs_sel, syn_r, 1'b0,
                        syn_r[pin_routing_pkg::SY_FS]);
    end
  end

  // aux clock select
  always_comb begin
    case (aux_sel)
      2'h1:    aux_nxt = syn_r[pin_routing_pkg::SY_BIDIR];
      2'h2:    aux_nxt = syn_r[pin_routing_pkg::SY_PINB];
      2'h3:    aux_nxt = syn_r[pin_routing_pkg::SY_PINA];
      default: aux_nxt = 1'b0;
    endcase
  end

  // all routed inputs leave through flops; a stable select gives
  // a plain one-cycle delay, so no glitch on unchanged routes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_clock            <= 1'b0;
      primary_second_input <= 1'b0;
      primary_bitclk       <= 1'b0;
      primary_framesync    <= 1'b0;
      primary_data_in      <= 1'b0;
      secondary_bitclk     <= 1'b0;
      secondary_framesync  <= 1'b0;
      secondary_enabled    <= 1'b0;
    end else begin
      aux_clock <= aux_nxt;
      primary_second_input <= pick3(din2_sel, syn_r,
        syn_r[pin_routing_pkg::SY_OUTP],
        syn_r[pin_routing_pkg::SY_DIN]);
      // the primary-pin reuse in the secondary path keeps the loop open
      primary_bitclk <= src_r[pin_routing_pkg::PBCLK_BIT] ?
        sbclk_nxt : syn_r[pin_routing_pkg::SY_BCLK];
      primary_framesync <= src_r[pin_routing_pkg::PFS_BIT] ?
        sfs_nxt : syn_r[pin_routing_pkg::SY_FS];
      primary_data_in <= sclk_r[pin_routing_pkg::PEN_BIT] &
        syn_r[pin_routing_pkg::SY_DIN];
      secondary_bitclk    <= sbclk_nxt;
      secondary_framesync <= sfs_nxt;
      secondary_enabled   <= sec_on;
    end
  end

  // ***************************************************************
  // out pin function and drive
  // ***************************************************************
  logic val_nxt;
  logic act_nxt;
  logic oe_nxt;
  logic pu_nxt;
  logic pd_nxt;

  // function select; disabled, input and reserved codes never drive
  always_comb begin
    act_nxt = 1'b1;
    case (fn)
      pin_routing_pkg::FN_GPO:    val_nxt = lvl;
      pin_routing_pkg::FN_IRQ:    val_nxt = irq_level;
      pin_routing_pkg::FN_DENSITY_MOD_CLOCK_OUT: val_nxt = density_mod_clock_out;
      pin_routing_pkg::FN_PDOUT:  val_nxt = primary_data_out;
      pin_routing_pkg::FN_PDOUT2: val_nxt = primary_data_out2;
      pin_routing_pkg::FN_SDOUT:  val_nxt = secondary_data_out;
      pin_routing_pkg::FN_SDOUT2: val_nxt = secondary_data_out2;
      pin_routing_pkg::FN_SBCLK:  val_nxt = sbclk_nxt;
      pin_routing_pkg::FN_SFS:    val_nxt = sfs_nxt;
      pin_routing_pkg::FN_GENERAL_CLOCK_OUTPUT: val_nxt = general_clock_output;
      pin_routing_pkg::FN_MUXED:  val_nxt = muxed_data_out;
      pin_routing_pkg::FN_LOOP:
        val_nxt = syn_r[pin_routing_pkg::SY_DIN];
      default: begin
        val_nxt = 1'b0;
        act_nxt = 1'b0;
      end
    endcase
  end

  // drive style: strong drive only on the levels the style allows
  always_comb begin
    oe_nxt = 1'b0;
    pu_nxt = 1'b0;
    pd_nxt = 1'b0;
    if (act_nxt) begin
      case (drv)
        pin_routing_pkg::DRV_PUSHPULL: oe_nxt = 1'b1;
        pin_routing_pkg::DRV_LOW_WEAKHI: begin
          oe_nxt = !val_nxt;
          pu_nxt = val_nxt;
        end
        pin_routing_pkg::DRV_LOW_HIZ: oe_nxt = !val_nxt;
        pin_routing_pkg::DRV_WEAKLO_HI: begin
          oe_nxt = val_nxt;
          pd_nxt = !val_nxt;
        end
        pin_routing_pkg::DRV_HIZ_HI: oe_nxt = val_nxt;
        default: oe_nxt = 1'b0; // 6-7 left floating, keeps them out
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_pin_out      <= 1'b0;
      out_pin_oe       <= 1'b0;
      out_pin_pullup   <= 1'b0;
      out_pin_pulldown <= 1'b0;
    end else begin
      out_pin_out      <= val_nxt;
      out_pin_oe       <= oe_nxt;
      out_pin_pullup   <= pu_nxt;
      out_pin_pulldown <= pd_nxt;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  sequence wr_func_s;
    acc && hwrite &&
      aidx == pin_routing_pkg::IDX_FUNC;
  endsequence

  sequence wait_s;
    !hreadyout ##1 hreadyout;
  endsequence

  aux_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
    aux_sel == 2'h3 |=> aux_clock == $past(syn_r[pin_routing_pkg::SY_PINA]))
    else $error("aux clock not from input pin a");

  din2_rsv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    din2_sel[2:1] == 2'h3 |=> !primary_second_input)
    else $error("reserved second input code routed");

  pbclk_own_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !src_r[pin_routing_pkg::PBCLK_BIT] |=>
      primary_bitclk == $past(syn_r[pin_routing_pkg::SY_BCLK]))
    else $error("primary bit clock not from its pin");

  pfs_sec_a: assert property (@(posedge hclk) disable iff (!hresetn)
    src_r[pin_routing_pkg::PFS_BIT] |=>
      primary_framesync == secondary_framesync)
    else $error("primary frame sync not secondary");

  rsv_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:8] == 24'h00_0000 && !src_r[7] && !sclk_r[0] &&
      sin_r[1:0] == 2'h0)
    else $error("reserved bit not zero");

  gpo_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fn == pin_routing_pkg::FN_GPO &&
      drv == pin_routing_pkg::DRV_PUSHPULL |=>
      out_pin_oe && out_pin_out == $past(lvl))
    else $error("gpo level not driven");

  hiz_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
    drv == pin_routing_pkg::DRV_HIZ |=> !out_pin_oe && !out_pin_pullup)
    else $error("hi-z style drives pin");

  din_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !sclk_r[pin_routing_pkg::PEN_BIT] |=> !primary_data_in)
    else $error("data input passed while disabled");

  sec_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sfs_sel == pin_routing_pkg::SEL_OFF |=>
      !secondary_enabled && !secondary_bitclk)
    else $error("secondary port live while off");

  sbclk_rsv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sbclk_sel == pin_routing_pkg::SEL_OUTP |=> !secondary_bitclk)
    else $error("reserved bit clock code routed");

  func_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_func_s |=> wait_s ##0 func_r == $past(hwdata[7:0]))
    else $error("function write not applied");

endmodule

`default_nettype wire

// ---- dv/serial_far_side.sv ----
// far side model: pin levels and same-clock data sources for the block
// assumes the bench commands the levels it wants at each step
`timescale 1ns/1ns
`default_nettype none

module serial_far_side (
  input  wire logic       hclk,
  input  wire logic [6:0] pin_cmd,
  input  wire logic [7:0] src_cmd,
  output var  logic [6:0] pins,
  output var  logic [7:0] srcs
);
  // start quiet so no unknown reaches the synchronisers
  initial begin
    pins = 7'h00;
    srcs = 8'h00;
  end
  // pins are asynchronous: move them 7 ns after each rising edge, away from hclk
  always @(posedge hclk) begin
    pins <= #7 pin_cmd;
  end
  // logic sources share hclk and change on its edge
  always @(posedge hclk) begin
    srcs <= src_cmd;
  end
endmodule

`default_nettype wire

// ---- dv/serial_port_pin_routing_bench.sv ----
// bench for the pin routing block: table of routings, then edge cases
// assumes one slave on AHB-Lite with hready fed from hreadyout
`timescale 1ns/1ns
`default_nettype none

module serial_port_pin_routing_bench;
  typedef struct packed {
    logic [7:0]  src;
    logic [7:0]  func;
    logic [7:0]  sclk;
    logic [6:0]  pins;
    logic [7:0]  srcs;
    logic [11:0] exp;
  } row_t;
  logic        hclk, hresetn, hsel, hwrite, hready;
  logic        hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [6:0]  pin_cmd, pins;
  logic [7:0]  src_cmd, srcs;
  logic        aux, sin2, pbclk, pfs, pdin, sbclk, sfs, sen;
  logic        po, poe, ppu, ppd;
  logic [11:0] obs;
  int          num_errors, n_checks;
  // cfg src, func, sclk, pins {outp,din,fs,bclk,b,a,bidir}, sources
  row_t rows [14] = '{
    '{8'h2C, 8'h29, 8'h94, 7'h2D, 8'h00, 12'hAFC},
    '{8'h53, 8'h52, 8'h36, 7'h62, 8'h01, 12'h772},
    '{8'h78, 8'h34, 8'hDC, 7'h13, 8'hDE, 12'h931},
    '{8'h16, 8'h81, 8'h82, 7'h31, 8'h08, 12'h58C},
    '{8'h00, 8'h95, 8'hA4, 7'h0C, 8'h00, 12'h27C},
    '{8'h00, 8'hD3, 8'h80, 7'h5F, 8'h00, 12'h308},
    '{8'h00, 8'hC1, 8'h80, 7'h00, 8'h10, 12'h00C},
    '{8'h00, 8'h40, 8'h80, 7'h00, 8'h40, 12'h000},
    '{8'h00, 8'hF1, 8'h80, 7'h00, 8'hFF, 12'h000},
    // functions 6, 7, 11 and 10: one source bit or pin alone, so a wrong pick reads 0; last row is the input function with all sources set
    '{8'h00, 8'h61, 8'h80, 7'h00, 8'h02, 12'h00C},
    '{8'h00, 8'h71, 8'h80, 7'h00, 8'h04, 12'h00C},
    '{8'h00, 8'hB1, 8'h80, 7'h00, 8'h80, 12'h00C},
    '{8'h00, 8'hA1, 8'hD2, 7'h10, 8'h00, 12'h13C},
    '{8'h00, 8'h11, 8'h80, 7'h00, 8'hFF, 12'h000}};
  logic [31:0] rsv_addr [3] = '{32'h3C, 32'h44, 32'h48};
  logic [31:0] rsv_mask [3] = '{32'h7F, 32'hFE, 32'hFC};

  assign hready = hreadyout;
  // undriven pin level is masked so only a strong drive is compared
  assign obs = {aux, sin2, pbclk, pfs, pdin, sbclk, sfs, sen,
                poe, po & poe, ppu, ppd};

  serial_far_side far (.hclk(hclk), .pin_cmd(pin_cmd), .src_cmd(src_cmd),
    .pins(pins), .srcs(srcs));

  serial_port_pin_routing uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .bidir_pin_one_in(pins[0]), .input_pin_a(pins[1]),
    .input_pin_b(pins[2]), .bitclk_pin(pins[3]),
    .framesync_pin(pins[4]), .data_in_pin(pins[5]),
    .out_pin_in(pins[6]), .primary_data_out(srcs[0]),
    .primary_data_out2(srcs[1]), .secondary_data_out(srcs[2]),
    .secondary_data_out2(srcs[3]), .muxed_data_out(srcs[4]),
    .irq_level(srcs[5]), .density_mod_clock_out(srcs[6]),
    .general_clock_output(srcs[7]), .out_pin_out(po),
    .out_pin_oe(poe), .out_pin_pullup(ppu), .out_pin_pulldown(ppd),
    .aux_clock(aux), .primary_second_input(sin2),
    .primary_bitclk(pbclk), .primary_framesync(pfs),
    .primary_data_in(pdin), .secondary_bitclk(sbclk),
    .secondary_framesync(sfs), .secondary_enabled(sen));

  // 50 ns period
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for hready high at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        num_errors++;
        print_verdict;
      end
      @(posedge hclk);
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
    rdv = hrdata;
    check(hresp, 32'h0);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(rdv, e);
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    num_errors = 0;
    n_checks = 0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    pin_cmd = 7'h00;
    src_cmd = 8'h00;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h3C, 32'h00);
    rd(32'h40, 32'h52);
    rd(32'h44, 32'h80);
    rd(32'h48, 32'h00);
    // routing table; software keeps reserved bits and drive codes legal
    foreach (rows[i]) begin
      ahb(1'b1, 32'h3C, {24'h0, rows[i].src});
      ahb(1'b1, 32'h40, {24'h0, rows[i].func});
      ahb(1'b1, 32'h44, {24'h0, rows[i].sclk});
      pin_cmd <= rows[i].pins;
      src_cmd <= rows[i].srcs;
      repeat (6) @(posedge hclk);
      #1 check(obs, rows[i].exp);
    end
    // reserved bits refuse ones; unmapped word reads zero
    foreach (rsv_addr[i]) begin
      ahb(1'b1, rsv_addr[i], 32'hFFFF_FFFF);
      rd(rsv_addr[i], rsv_mask[i]);
    end
    ahb(1'b1, 32'h4C, 32'hFF);
    rd(32'h4C, 32'h00);
    // gpo level flips at the edge where its write completes, checked with no extra wait
    ahb(1'b1, 32'h40, 32'h21);
    #1 check(po, 32'h0);
    ahb(1'b1, 32'h40, 32'h29);
    #1 check(po, 32'h1);
    // second reset in mid-run restores defaults
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h40, 32'h52);
    rd(32'h44, 32'h80);
    print_verdict;
  end
endmodule

`default_nettype wire
